/* File: rtl/lst_pkg.sv */
// Package: register map, field layout and reset values of the lane-mask self-test block
package lst_pkg;

  // ***********************************************
  // Sizes
  // ***********************************************
  localparam int NUM_CHAN      = 2;
  localparam int PAT_W         = 24;
  localparam int TX_MAIN_W     = 10;
  localparam int TX_EXTRA_W    = 4;
  localparam int TX_LANES      = TX_MAIN_W + TX_EXTRA_W;
  localparam int RX_LANES      = 14;
  localparam int REP_W         = 7;
  localparam int ERR_W         = 16;
  localparam int ADDR_W        = 10;

  // ***********************************************
  // Register offsets (byte addresses), one bank per channel
  // ***********************************************
  localparam logic [ADDR_W-1:0] OFF_PAT_LO  = 10'h188;
  localparam logic [ADDR_W-1:0] OFF_TXS_LO  = 10'h18C;
  localparam logic [ADDR_W-1:0] OFF_RXS_LO  = 10'h190;
  localparam logic [ADDR_W-1:0] OFF_CTL_LO  = 10'h1A0;
  localparam logic [ADDR_W-1:0] OFF_STS_LO  = 10'h1A4;
  localparam logic [ADDR_W-1:0] OFF_PAT_HI  = 10'h288;
  localparam logic [ADDR_W-1:0] OFF_TXS_HI  = 10'h28C;
  localparam logic [ADDR_W-1:0] OFF_RXS_HI  = 10'h290;
  localparam logic [ADDR_W-1:0] OFF_CTL_HI  = 10'h2A0;
  localparam logic [ADDR_W-1:0] OFF_STS_HI  = 10'h2A4;

  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic [PAT_W-1:0]      RST_PAT       = 24'h02CCFD;
  localparam logic [TX_MAIN_W-1:0]  RST_TX_MAIN   = 10'h3FF;
  localparam logic [TX_EXTRA_W-1:0] RST_TX_EXTRA  = 4'h0;
  localparam logic [RX_LANES-1:0]   RST_RX        = 14'h1FFF;
  localparam logic [REP_W-1:0]      RST_REP       = 7'h19;

  // ***********************************************
  // Control and status fields
  // ***********************************************
  localparam int CTL_START_BIT = 0;
  localparam int CTL_ECLR_BIT  = 1;
  localparam int CTL_REP_LSB   = 3;
  localparam int STS_BUSY_BIT  = 0;
  localparam int STS_DONE_BIT  = 1;
  localparam int STS_ERR_LSB   = 16;

  // Register kinds inside a channel bank
  typedef enum logic [2:0] {
    RK_NONE = 3'h0,
    RK_PAT  = 3'h1,
    RK_TXS  = 3'h2,
    RK_RXS  = 3'h3,
    RK_CTL  = 3'h4,
    RK_STS  = 3'h5
  } lst_reg_t;

  // Generator states
  typedef enum logic [2:0] {
    GS_IDLE = 3'b001,
    GS_RUN  = 3'b010,
    GS_DONE = 3'b100
  } lst_gen_t;

endpackage

/* File: rtl/lst_chan.sv */
// Per-channel lane gating, pattern store replay and masked error accumulation
`timescale 1ns/1ps
module lst_chan
  import lst_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Configuration
  input  wire logic                start,
  input  wire logic                err_clr,
  input  wire logic [REP_W-1:0]    rep_count,
  input  wire logic [PAT_W-1:0]    pattern,
  input  wire logic [TX_LANES-1:0] tx_sel,
  input  wire logic [RX_LANES-1:0] rx_sel,
  input  wire logic [RX_LANES-1:0] rx_err,
  // Lane controls
  output logic      [TX_LANES-1:0] tx_drive,
  output logic      [TX_LANES-1:0] tx_idle,
  output logic      [TX_LANES-1:0] tx_pwr_down,
  output logic      [RX_LANES-1:0] rx_train_en,
  // Pattern stream and status
  output logic      [PAT_W-1:0]    pat_word,
  output logic                     pat_valid,
  output logic                     done,
  output logic                     busy,
  output logic      [ERR_W-1:0]    err_cnt
);

  // ***********************************************
  // Replay sequencer
  // ***********************************************
  lst_gen_t             state_q;
  logic                 half_q;
  logic [REP_W-1:0]     left_q;
  logic [4:0]           nerr;

  function automatic logic [4:0] popcnt(input logic [RX_LANES-1:0] v);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < RX_LANES; i++) begin
      s = s + {4'h0, v[i]};
    end
    return s;
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= GS_IDLE;
      half_q    <= 1'b0;
      left_q    <= '0;
      pat_valid <= 1'b0;
      pat_word  <= '0;
      done      <= 1'b0;
    end else begin
      done      <= 1'b0;
      pat_valid <= 1'b0;
      case (state_q)
        GS_IDLE: begin
          if (start) begin
            // A count of zero sends nothing and finishes at once
            if (rep_count == '0) begin
              state_q <= GS_DONE;
            end else begin
              state_q <= GS_RUN;
              left_q  <= rep_count;
              half_q  <= 1'b0;
            end
          end
        end
        GS_RUN: begin
          pat_valid <= 1'b1;
          pat_word  <= pattern;
          half_q    <= ~half_q;
          // Two frames form one buffer transfer
          if (half_q) begin
            left_q <= left_q - 7'h01;
            if (left_q == 7'h01) begin
              state_q <= GS_DONE;
            end
          end
        end
        GS_DONE: begin
          done    <= 1'b1;
          state_q <= GS_IDLE;
        end
        default: state_q <= GS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_q == GS_RUN);
    end
  end

  // ***********************************************
  // Lane gating
  // ***********************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_drive    <= '0;
      tx_idle     <= '1;
      tx_pwr_down <= '0;
      rx_train_en <= '0;
    end else begin
      // Deselected lanes stay idle and never carry pattern data
      tx_drive    <= (state_q == GS_RUN) ? tx_sel : '0;
      tx_idle     <= (state_q == GS_RUN) ? ~tx_sel : '1;
      tx_pwr_down <= ~tx_sel;
      rx_train_en <= rx_sel;
    end
  end

  // ***********************************************
  // Error accumulation
  // ***********************************************
  assign nerr = popcnt(rx_err & rx_sel);

  always_ff @(posedge clk) begin
    if (rst || err_clr) begin
      err_cnt <= '0;
    end else if (err_cnt > ({ERR_W{1'b1}} - {11'h000, nerr})) begin
      // Saturate rather than wrap so a long soak never looks clean
      err_cnt <= '1;
    end else begin
      err_cnt <= err_cnt + {11'h000, nerr};
    end
  end

endmodule // lst_chan

/* File: rtl/lst_lane_masks.sv */
// Top of the lane-mask self-test block: Avalon-MM register slave and two channel instances
`timescale 1ns/1ps

module lst_lane_masks
  import lst_pkg::*;
(
  // Clock and reset
  input  wire logic                         CLK,
  input  wire logic                         SYS_RST,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]            AVS_ADDRESS,
  input  wire logic                         AVS_READ,
  input  wire logic                         AVS_WRITE,
  input  wire logic [31:0]                  AVS_WRITEDATA,
  input  wire logic [3:0]                   AVS_BYTEENABLE,
  output logic      [31:0]                  AVS_READDATA,
  output logic                              AVS_WAITREQUEST,
  // Receive lane error flags, one group per channel
  input  wire logic [NUM_CHAN*RX_LANES-1:0] RX_LANE_ERR,
  // Transmit lane controls
  output logic      [NUM_CHAN*TX_LANES-1:0] TX_LANE_DRIVE,
  output logic      [NUM_CHAN*TX_LANES-1:0] TX_ELEC_IDLE,
  output logic      [NUM_CHAN*TX_LANES-1:0] TX_PWR_REDUCE,
  // Receive lane controls
  output logic      [NUM_CHAN*RX_LANES-1:0] RX_TRAIN_EN,
  // Pattern stream
  output logic      [NUM_CHAN*PAT_W-1:0]    PAT_WORD,
  output logic      [NUM_CHAN-1:0]          PAT_VALID,
  output logic      [NUM_CHAN-1:0]          PAT_DONE
);

  // ***********************************************
  // Address decode
  // ***********************************************
  // Returns the register kind at a byte address
  function automatic lst_reg_t reg_kind(input logic [ADDR_W-1:0] a);
    lst_reg_t k;
    k = RK_NONE;
    case (a)
      OFF_PAT_LO, OFF_PAT_HI: k = RK_PAT;
      OFF_TXS_LO, OFF_TXS_HI: k = RK_TXS;
      OFF_RXS_LO, OFF_RXS_HI: k = RK_RXS;
      OFF_CTL_LO, OFF_CTL_HI: k = RK_CTL;
      OFF_STS_LO, OFF_STS_HI: k = RK_STS;
      default:                k = RK_NONE;
    endcase
    return k;
  endfunction

  // Returns 1 for the upper channel bank
  function automatic logic reg_chan(input logic [ADDR_W-1:0] a);
    logic c;
    c = (a == OFF_PAT_HI) || (a == OFF_TXS_HI) || (a == OFF_RXS_HI) ||
        (a == OFF_CTL_HI) || (a == OFF_STS_HI);
    return c;
  endfunction

  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ***********************************************
  // Bus handshake
  // ***********************************************
  logic        wait_q;
  logic        req;
  logic        wr_go;
  lst_reg_t    kind;
  logic        chan;
  logic [31:0] rd_d;

  assign req   = AVS_READ || AVS_WRITE;
  assign kind  = reg_kind(AVS_ADDRESS);
  assign chan  = reg_chan(AVS_ADDRESS);
  // Writes land on the edge where the master sees waitrequest low
  assign wr_go = AVS_WRITE && !wait_q;

  // One wait state: data is built in the first cycle, released in the second
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wait_q <= 1'b1;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (req) begin
      wait_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (!wait_q) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !req;
    end
  end

  // ***********************************************
  // Register state, one bank per channel
  // ***********************************************
  logic [PAT_W-1:0]      pat_q     [NUM_CHAN];
  logic [TX_MAIN_W-1:0]  txm_q     [NUM_CHAN];
  logic [TX_EXTRA_W-1:0] txx_q     [NUM_CHAN];
  logic [RX_LANES-1:0]   rxs_q     [NUM_CHAN];
  logic [REP_W-1:0]      rep_q     [NUM_CHAN];
  logic                  start_q   [NUM_CHAN];
  logic                  eclr_q    [NUM_CHAN];
  logic                  dflag_q   [NUM_CHAN];
  logic                  busy_w    [NUM_CHAN];
  logic                  done_w    [NUM_CHAN];
  logic [ERR_W-1:0]      err_w     [NUM_CHAN];

  genvar c;
  generate
    for (c = 0; c < NUM_CHAN; c++) begin : g_bank
      logic        hit;
      logic [31:0] wv_pat;
      logic [31:0] wv_txs;
      logic [31:0] wv_rxs;
      logic [31:0] wv_ctl;

      assign hit = wr_go && (chan == 1'(c));

      // Merged write values, one per register so each has a single driver
      assign wv_pat = be_merge({8'h00, pat_q[c]}, AVS_WRITEDATA, AVS_BYTEENABLE);
      assign wv_txs = be_merge({18'h00000, txx_q[c], txm_q[c]}, AVS_WRITEDATA, AVS_BYTEENABLE);
      assign wv_rxs = be_merge({18'h00000, rxs_q[c]}, AVS_WRITEDATA, AVS_BYTEENABLE);
      assign wv_ctl = be_merge({22'h000000, rep_q[c], 3'h0}, AVS_WRITEDATA, AVS_BYTEENABLE);

      // ***********************************************
      // Pattern store
      // ***********************************************
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          pat_q[c] <= RST_PAT;
        end else if (hit && kind == RK_PAT) begin
          pat_q[c] <= wv_pat[PAT_W-1:0];
        end
      end

      // ***********************************************
      // Transmit lane select
      // ***********************************************
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          txm_q[c] <= RST_TX_MAIN;
          txx_q[c] <= RST_TX_EXTRA;
        end else if (hit && kind == RK_TXS) begin
          txm_q[c] <= wv_txs[TX_MAIN_W-1:0];
          txx_q[c] <= wv_txs[TX_LANES-1:TX_MAIN_W];
        end
      end

      // ***********************************************
      // Receive lane select
      // ***********************************************
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          rxs_q[c] <= RST_RX;
        end else if (hit && kind == RK_RXS) begin
          rxs_q[c] <= wv_rxs[RX_LANES-1:0];
        end
      end

      // ***********************************************
      // Control: repeat count, start and error-clear strobes
      // ***********************************************
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          rep_q[c]   <= RST_REP;
          start_q[c] <= 1'b0;
          eclr_q[c]  <= 1'b0;
        end else begin
          start_q[c] <= 1'b0;
          eclr_q[c]  <= 1'b0;
          if (hit && kind == RK_CTL) begin
            rep_q[c]   <= wv_ctl[CTL_REP_LSB +: REP_W];
            start_q[c] <= AVS_BYTEENABLE[0] && AVS_WRITEDATA[CTL_START_BIT];
            eclr_q[c]  <= AVS_BYTEENABLE[0] && AVS_WRITEDATA[CTL_ECLR_BIT];
          end
        end
      end

      // ***********************************************
      // Sticky completion flag, write one to clear
      // ***********************************************
      // A completion in the clearing cycle must not be lost, so set wins
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          dflag_q[c] <= 1'b0;
        end else if (done_w[c]) begin
          dflag_q[c] <= 1'b1;
        end else if (hit && kind == RK_STS && AVS_BYTEENABLE[0] && AVS_WRITEDATA[STS_DONE_BIT]) begin
          dflag_q[c] <= 1'b0;
        end
      end

      // ***********************************************
      // Channel datapath
      // ***********************************************
      lst_chan u_chan (
        .clk         (CLK),
        .rst         (SYS_RST),
        .start       (start_q[c]),
        .err_clr     (eclr_q[c]),
        .rep_count   (rep_q[c]),
        .pattern     (pat_q[c]),
        .tx_sel      ({txx_q[c], txm_q[c]}),
        .rx_sel      (rxs_q[c]),
        .rx_err      (RX_LANE_ERR[c*RX_LANES +: RX_LANES]),
        .tx_drive    (TX_LANE_DRIVE[c*TX_LANES +: TX_LANES]),
        .tx_idle     (TX_ELEC_IDLE[c*TX_LANES +: TX_LANES]),
        .tx_pwr_down (TX_PWR_REDUCE[c*TX_LANES +: TX_LANES]),
        .rx_train_en (RX_TRAIN_EN[c*RX_LANES +: RX_LANES]),
        .pat_word    (PAT_WORD[c*PAT_W +: PAT_W]),
        .pat_valid   (PAT_VALID[c]),
        .done        (PAT_DONE[c]),
        .busy        (busy_w[c]),
        .err_cnt     (err_w[c])
      );

      assign done_w[c] = PAT_DONE[c];
    end
  endgenerate

  // ***********************************************
  // Read data
  // ***********************************************
  // Reserved and unmapped bits read as zero
  always_comb begin
    rd_d = 32'h00000000;
    case (kind)
      RK_PAT: rd_d[PAT_W-1:0]    = pat_q[chan];
      RK_TXS: rd_d[TX_LANES-1:0] = {txx_q[chan], txm_q[chan]};
      RK_RXS: rd_d[RX_LANES-1:0] = rxs_q[chan];
      RK_CTL: rd_d[CTL_REP_LSB +: REP_W] = rep_q[chan];
      RK_STS: begin
        rd_d[STS_BUSY_BIT]           = busy_w[chan];
        rd_d[STS_DONE_BIT]           = dflag_q[chan];
        rd_d[STS_ERR_LSB +: ERR_W]   = err_w[chan];
      end
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ && wait_q) begin
      AVS_READDATA <= rd_d;
    end
  end

endmodule // lst_lane_masks

/* File: bench/lst_lane_masks_assertions.sv */
// Checker: port-level properties of the lane-mask self-test block
`timescale 1ns/1ps
module lst_lane_masks_chk
  import lst_pkg::*;
(
  // Clock and reset
  input wire logic                         CLK,
  input wire logic                         SYS_RST,
  // Bus handshake
  input wire logic                         AVS_READ,
  input wire logic                         AVS_WRITE,
  input wire logic                         AVS_WAITREQUEST,
  // Lane controls and pattern stream
  input wire logic [NUM_CHAN*TX_LANES-1:0] TX_LANE_DRIVE,
  input wire logic [NUM_CHAN*TX_LANES-1:0] TX_ELEC_IDLE,
  input wire logic [NUM_CHAN*TX_LANES-1:0] TX_PWR_REDUCE,
  input wire logic [NUM_CHAN-1:0]          PAT_VALID,
  input wire logic [NUM_CHAN-1:0]          PAT_DONE
);
  // ********
  // Frame run length of channel 0
  // ********
  logic [7:0] run_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) run_q <= 8'h00;
    else if (PAT_VALID[0]) run_q <= run_q + 8'h01;
    else run_q <= 8'h00;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // ********
  // Properties
  // ********
  a_idle_vs_drive: assert property (TX_ELEC_IDLE == ~TX_LANE_DRIVE)
    else $error("idle and drive not complementary");
  a_masked_quiet: assert property ((TX_LANE_DRIVE & TX_PWR_REDUCE) == '0)
    else $error("power-reduced lane drives pattern");
  a_run_lanes: assert property (PAT_VALID[0] && $past(PAT_VALID[0]) |->
    TX_LANE_DRIVE[13:0] == ~TX_PWR_REDUCE[13:0]) else $error("drive differs from select during run");
  a_frames_paired: assert property ($fell(PAT_VALID[0]) |->
    run_q[0] == 1'b0 && run_q >= 8'h02 && run_q <= 8'h7E) else $error("frame run length wrong");
  a_done_follows: assert property ($fell(PAT_VALID[0]) |-> ##[0:2] PAT_DONE[0])
    else $error("no done after frames");
  a_done_pulse: assert property (PAT_DONE[0] |=> !PAT_DONE[0] && !PAT_VALID[0])
    else $error("done longer than one cycle");
  a_req_answer: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  a_no_spurious: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
    else $error("answer without request");

  c_run_done: cover property (PAT_DONE[0]);
  c_long_run: cover property ($fell(PAT_VALID[0]) && run_q == 8'h7E);
  c_masked: cover property (PAT_VALID[0] && TX_PWR_REDUCE[13:0] != 14'h0000);
endmodule // lst_lane_masks_chk

bind lst_lane_masks lst_lane_masks_chk chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_LANE_DRIVE(TX_LANE_DRIVE),
  .TX_ELEC_IDLE(TX_ELEC_IDLE), .TX_PWR_REDUCE(TX_PWR_REDUCE), .PAT_VALID(PAT_VALID), .PAT_DONE(PAT_DONE));

/* File: bench/lst_mem_model.sv */
// Far-side memory module model: counts channel 0 frames, raises lane errors on command
`timescale 1ns/1ps
module lst_mem_model
  import lst_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Error injection command
  input  wire logic                         err_start,
  input  wire logic [NUM_CHAN*RX_LANES-1:0] err_mask,
  input  wire logic [7:0]                   err_len,
  // Link side
  input  wire logic [NUM_CHAN-1:0]          pat_valid,
  output logic      [NUM_CHAN*RX_LANES-1:0] rx_err,
  output logic      [15:0]                  frames0
);
  logic [7:0] left_q;
  // Error flags only while a burst runs; no stale value between bursts
  always_ff @(posedge clk) begin
    if (rst) left_q <= 8'h00;
    else if (err_start) left_q <= err_len;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end
  assign rx_err = (left_q != 8'h00) ? err_mask : '0;
  always_ff @(posedge clk) begin
    if (rst) frames0 <= 16'h0000;
    else if (pat_valid[0]) frames0 <= frames0 + 16'h0001;
  end
endmodule // lst_mem_model

/* File: bench/lst_lane_masks_tb.sv */
// Testbench: register map, lane gating, pattern runs and masked error counts
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module lst_lane_masks_tb;
  import lst_pkg::*;
  logic        clk, rst, avs_read, avs_write, err_start;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest;
  logic [27:0] rx_err, err_mask, drive, idle, pwr, train;
  logic [47:0] pat_word;
  logic [1:0]  pat_valid, pat_done;
  logic [15:0] frames0, f0;
  logic [7:0]  err_len;
  int          num_errors, check_count;
  logic [9:0]  offs [8] = '{10'h188, 10'h18C, 10'h190, 10'h288, 10'h28C, 10'h290, 10'h1A0, 10'h100};
  logic [31:0] rsts [8] = '{32'h0002CCFD, 32'h000003FF, 32'h00001FFF, 32'h0002CCFD, 32'h000003FF,
                            32'h00001FFF, 32'h000000C8, 32'h00000000};
  logic [6:0]  cnts [3] = '{7'h00, 7'h03, 7'h3F};

  lst_lane_masks dut_u (.CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .RX_LANE_ERR(rx_err),
    .TX_LANE_DRIVE(drive), .TX_ELEC_IDLE(idle), .TX_PWR_REDUCE(pwr), .RX_TRAIN_EN(train),
    .PAT_WORD(pat_word), .PAT_VALID(pat_valid), .PAT_DONE(pat_done));
  lst_mem_model mem_u (.clk(clk), .rst(rst), .err_start(err_start), .err_mask(err_mask),
    .err_len(err_len), .pat_valid(pat_valid), .rx_err(rx_err), .frames0(frames0));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ********
  // Tasks
  // ********
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus_access(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic wait_done();
    int n;
    for (n = 0; n < 400 && pat_done[0] !== 1'b1; n++) begin
      @(posedge clk);
      if (pat_valid[0] === 1'b1) begin
        `CHK("pattern word", 24'h123456, pat_word[23:0])
        `CHK("drive on run", 14'h000F, drive[13:0])
        `CHK("idle on run", 14'h3FF0, idle[13:0])
      end
    end
    if (n >= 400) begin
      num_errors++;
      close_out();
    end
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    num_errors = 0;
    check_count = 0;
    rst = 1'b1;
    {avs_read, avs_write, err_start} = 3'b000;
    avs_address = 10'h000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    err_mask = 28'h0000000;
    err_len = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Lane controls load on the first edge out of reset; look one edge later
    repeat (2) @(posedge clk);
    `CHK("reset power", 14'h3C00, pwr[13:0])
    `CHK("reset train", 14'h1FFF, train[13:0])
    `CHK("reset idle", 28'hFFFFFFF, idle)
    for (int i = 0; i < 8; i++) begin
      bus_access(1'b0, offs[i], 32'h00000000, 4'hF);
      `CHK("reset value", rsts[i], rd)
    end
    $display("test reset_values done");

    bus_access(1'b1, 10'h18C, 32'hFFFFFFFF, 4'hF);
    bus_access(1'b0, 10'h18C, 32'h00000000, 4'hF);
    `CHK("tx reserved", 32'h00003FFF, rd)
    bus_access(1'b1, 10'h290, 32'hFFFFFFFF, 4'hF);
    bus_access(1'b0, 10'h290, 32'h00000000, 4'hF);
    `CHK("rx reserved", 32'h00003FFF, rd)
    bus_access(1'b1, 10'h188, 32'hFFFFFFFF, 4'h2);
    bus_access(1'b0, 10'h188, 32'h00000000, 4'hF);
    `CHK("pattern byte", 32'h0002FFFD, rd)
    bus_access(1'b1, 10'h188, 32'hFF123456, 4'hF);
    bus_access(1'b1, 10'h18C, 32'h0000000F, 4'hF);
    bus_access(1'b1, 10'h290, 32'h00000F0F, 4'hF);
    repeat (3) @(posedge clk);
    `CHK("masked power", 14'h3FF0, pwr[13:0])
    `CHK("masked train", 14'h0F0F, train[27:14])
    $display("test masks done");

    for (int i = 0; i < 3; i++) begin
      f0 = frames0;
      bus_access(1'b1, 10'h1A0, {22'h000000, cnts[i], 3'b001}, 4'hF);
      wait_done();
      repeat (3) @(posedge clk);
      `CHK("frame count", {8'h00, cnts[i], 1'b0}, frames0 - f0)
      `CHK("drive after run", 14'h0000, drive[13:0])
    end
    bus_access(1'b0, 10'h1A4, 32'h00000000, 4'hF);
    `CHK("done flag", 32'h00000002, rd)
    bus_access(1'b1, 10'h1A4, 32'h00000002, 4'hF);
    bus_access(1'b0, 10'h1A4, 32'h00000000, 4'hF);
    `CHK("done cleared", 32'h00000000, rd)
    $display("test pattern_runs done");

    bus_access(1'b1, 10'h190, 32'h00000005, 4'hF);
    bus_access(1'b1, 10'h1A0, 32'h00000002, 4'hF);
    bus_access(1'b1, 10'h2A0, 32'h00000002, 4'hF);
    @(posedge clk);
    err_mask <= 28'h003C00F;
    err_len <= 8'h04;
    err_start <= 1'b1;
    @(posedge clk);
    err_start <= 1'b0;
    repeat (8) @(posedge clk);
    bus_access(1'b0, 10'h1A4, 32'h00000000, 4'hF);
    `CHK("errors ch0", 16'h0008, rd[31:16])
    bus_access(1'b0, 10'h2A4, 32'h00000000, 4'hF);
    `CHK("errors ch1", 16'h0010, rd[31:16])
    $display("test error_masking done");
    close_out();
  end
endmodule // lst_lane_masks_tb
